/* File: src/nct_params.svh */
// Constants of the charge timer, thermal limit and indicator block
`ifndef NCT_PARAMS_SVH
`define NCT_PARAMS_SVH

// Clock and prescaler timing
`define NCT_SYS_CLK_KHZ          50000
`define NCT_EIGHTH_SEC_MS        125
`define NCT_EIGHTH_CYCLES        (`NCT_EIGHTH_SEC_MS * `NCT_SYS_CLK_KHZ)
`define NCT_EIGHTHS_PER_SEC      8
`define NCT_SEC_PER_MIN          60

// Charge timers, in minutes, tenths of minutes and seconds; resistor clamp in kilohms
`define NCT_PRECHARGE_LIMIT_MIN  30
`define NCT_PRECHARGE_LIMIT_SEC  (`NCT_PRECHARGE_LIMIT_MIN * `NCT_SEC_PER_MIN)
`define NCT_BLANK_TENTH_MIN      43
`define NCT_BLANK_SEC            (`NCT_BLANK_TENTH_MIN * `NCT_SEC_PER_MIN / 10)
`define NCT_FAST_SEC_PER_KOHM    90
`define NCT_RT_MIN_KOHM          8'h14
`define NCT_RT_MAX_KOHM          8'hF0

// Thermistor ratio codes, ratio times 1024
`define NCT_COLD_START_LIMIT     10'h2EC
`define NCT_HOT_START_LIMIT      10'h152
`define NCT_THERMAL_STOP_LIMIT   10'h129
`define NCT_SLOPE_CODES_PER_MIN  10'h005

// Sense targets, magnitude in mV
`define NCT_LIN_FAST_MV          8'h79
`define NCT_LIN_TOPOFF_MV        8'h21
`define NCT_CMP_FAST_MV          8'h6B
`define NCT_CMP_TOPOFF_MV        8'h1D

// Register offsets
`define NCT_REG_CTRL             8'h00
`define NCT_REG_STATUS           8'h04
`define NCT_REG_MASK             8'h08
`define NCT_REG_STATE            8'h0C
`define NCT_REG_TIMER            8'h10
`define NCT_REG_THERM            8'h14

// Control fields and reset value
`define NCT_CTRL_ENABLE_BIT      0
`define NCT_CTRL_RESTART_BIT     1
`define NCT_CTRL_RESET           1'h1

// Event status fields
`define NCT_EVT_WIDTH            5
`define NCT_EVT_DONE             0
`define NCT_EVT_FAULT            1
`define NCT_EVT_SLOPE            2
`define NCT_EVT_TIMEOUT          3
`define NCT_EVT_THSTOP           4

`endif

/* File: src/nct_pkg.sv */
// Types of the charge timer, thermal limit and indicator block
package nct_pkg;

    typedef enum logic [2:0] {
        NCT_RESET     = 3'b000,
        NCT_PRESENCE  = 3'b001,
        NCT_PRECHARGE = 3'b010,
        NCT_FAST      = 3'b011,
        NCT_TOPOFF    = 3'b100,
        NCT_DONE      = 3'b101,
        NCT_FAULT     = 3'b110,
        NCT_DISCHARGE = 3'b111
    } nct_state_t;

    typedef enum logic {
        NCT_STYLE_LINEAR     = 1'b0,
        NCT_STYLE_COMPARATOR = 1'b1
    } nct_style_t;

endpackage

/* File: src/nct_indicator.sv */
// Open-drain indicator driver with optional blink
`timescale 1ns/1ps
`default_nettype none

module nct_indicator (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic active,
    input  wire logic blink,
    input  wire logic phase,
    output var  logic pin_out,
    output var  logic pin_oe
);

    // Pin is only ever pulled low
    always_ff @(posedge sys_clk) begin
        pin_out <= 1'b0;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pin_oe <= 1'b0;
        end else begin
            pin_oe <= active & (~blink | phase);
        end
    end

endmodule // nct_indicator

`default_nettype wire

/* File: src/nct_charge_ctrl.sv */
// Charge state, timers, thermal limits, indicators and registers
//
// Function
// - Strap picks linear or comparator regulation style.
// - Fast target in fast charge, lower top-off target in pre-charge and top-off, zero otherwise.
// - Pre-charge limited to 30 minutes from internal timebase.
// - Fast timeout is 1.5 times resistor kilohms minutes, 0.5 to 6 hours.
// - Fast timeout clears timer and advances to top-off.
// - Top-off timeout is half the fast timeout.
// - Top-off timeout enters done.
// - Start only while thermistor ratio lies between 0.73 and 0.33.
// - Stop limit 0.29 during pre-charge gives fault.
// - Stop limit during fast or top-off gives done.
// - Temperature slope above threshold ends fast charge into top-off.
// - Both indicators open-drain: low when active, released otherwise.
// - Charge indicator blinks 1 Hz 50% while charging, else released.
// - Result indicator steady low when done, 4 Hz blink on fault.
// - Both indicators released without cell or with discharge latch set.
// - Slope threshold 0.5 degrees per minute, ignored first 4.3 minutes.
// - Pre-charge exits to fast above 1.0 V, else fault at limit.
// - Undervoltage lockout forces reset state and clears timers.
//
// Added by the designer: the register offsets and the plain strobed port.
`include "nct_params.svh"
`timescale 1ns/1ps
`default_nettype none

module nct_charge_ctrl #(
    parameter int EIGHTH_CYCLES = `NCT_EIGHTH_CYCLES
) (
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    input  wire logic         uvlo_active,
    input  wire logic         mode_strap_bias,
    input  wire logic [7:0]   rt_kohm,
    input  wire logic [9:0]   thermistor_sense_input,
    input  wire logic         cell_inserted,
    input  wire logic         cell_open,
    input  wire logic         above_precharge_exit_voltage,
    input  wire logic         discharge_detect,
    input  wire logic         charge_current_detect,
    input  wire logic [7:0]   reg_addr,
    input  wire logic [31:0]  reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output var  logic [31:0]  reg_rdata,
    output var  logic         irq,
    output var  nct_pkg::nct_style_t regulation_style,
    output var  logic         fast_sense_target,
    output var  logic [7:0]   sense_target_mv,
    output var  logic         charge_drive_output_en,
    output var  logic         charge_indicator_out,
    output var  logic         charge_indicator_oe,
    output var  logic         result_indicator_out,
    output var  logic         result_indicator_oe
);
    import nct_pkg::*;

    nct_state_t               state;
    nct_state_t               next_state;
    logic                     style_loaded;
    logic [22:0]              presc;
    logic [2:0]               eighth;
    logic                     sec_tick;
    logic [15:0]              timer;
    logic                     timer_clear;
    logic [5:0]               sec_in_min;
    logic [9:0]               slope_ref;
    logic                     slope_ref_valid;
    logic                     slope_hit;
    logic [7:0]               rt_clamped;
    logic [15:0]              fast_limit;
    logic [15:0]              topoff_limit;
    logic                     therm_in_range;
    logic                     therm_stop;
    logic                     ctrl_enable;
    logic                     restart_req;
    logic [`NCT_EVT_WIDTH-1:0] status;
    logic [`NCT_EVT_WIDTH-1:0] mask;
    logic [`NCT_EVT_WIDTH-1:0] events;
    logic [`NCT_EVT_WIDTH-1:0] next_status;
    logic                     charging;
    logic                     no_override;

    // Strap caught once after reset release
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            style_loaded     <= 1'b0;
            regulation_style <= NCT_STYLE_LINEAR;
        end else if (!style_loaded) begin
            style_loaded     <= 1'b1;
            regulation_style <= nct_style_t'(mode_strap_bias);
        end
    end

    // Shared prescaler: eighth-second steps, second tick
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            presc <= 23'h000000;
            eighth <= 3'h0;
        end else if (presc == 23'(EIGHTH_CYCLES - 1)) begin
            presc <= 23'h000000;
            eighth <= eighth + 3'h1;
        end else begin
            presc <= presc + 23'h000001;
        end
    end

    assign sec_tick = (presc == 23'(EIGHTH_CYCLES - 1))
                   && (eighth == 3'(`NCT_EIGHTHS_PER_SEC - 1));

    // Timeout limits from the timing resistor
    always_comb begin
        rt_clamped = rt_kohm;
        if (rt_kohm < `NCT_RT_MIN_KOHM) begin
            rt_clamped = `NCT_RT_MIN_KOHM;
        end else if (rt_kohm > `NCT_RT_MAX_KOHM) begin
            rt_clamped = `NCT_RT_MAX_KOHM;
        end
    end

    assign fast_limit   = 16'(rt_clamped * 16'(`NCT_FAST_SEC_PER_KOHM));
    assign topoff_limit = fast_limit >> 1;

    // Thermistor ratio falls as temperature rises
    assign therm_in_range = (thermistor_sense_input < `NCT_COLD_START_LIMIT)
                         && (thermistor_sense_input > `NCT_HOT_START_LIMIT);
    assign therm_stop     = thermistor_sense_input <= `NCT_THERMAL_STOP_LIMIT;
    assign slope_hit      = slope_ref_valid && (sec_in_min == 6'(`NCT_SEC_PER_MIN - 1))
                         && sec_tick && (slope_ref > thermistor_sense_input)
                         && ((slope_ref - thermistor_sense_input) >= `NCT_SLOPE_CODES_PER_MIN);
    assign no_override    = !uvlo_active && !discharge_detect && !restart_req && !cell_open;

    // State transitions
    always_comb begin
        next_state  = state;
        timer_clear = 1'b0;
        events      = '0;
        if (uvlo_active) begin
            next_state  = NCT_RESET;
            timer_clear = 1'b1;
        end else if (discharge_detect && state != NCT_RESET && state != NCT_DISCHARGE) begin
            next_state  = NCT_DISCHARGE;
            timer_clear = 1'b1;
        end else if (restart_req && state != NCT_RESET) begin
            next_state  = NCT_PRESENCE;
            timer_clear = 1'b1;
        end else begin
            unique case (state)
                NCT_RESET: begin
                    next_state  = NCT_PRESENCE;
                    timer_clear = 1'b1;
                end
                NCT_PRESENCE: begin
                    timer_clear = 1'b1;
                    if (cell_inserted && !cell_open && therm_in_range && ctrl_enable) begin
                        next_state = NCT_PRECHARGE;
                    end
                end
                NCT_PRECHARGE: begin
                    if (cell_open) begin
                        next_state  = NCT_PRESENCE;
                        timer_clear = 1'b1;
                    end else if (therm_stop) begin
                        next_state  = NCT_FAULT;
                        events[`NCT_EVT_THSTOP] = 1'b1;
                        events[`NCT_EVT_FAULT]  = 1'b1;
                    end else if (above_precharge_exit_voltage) begin
                        next_state  = NCT_FAST;
                        timer_clear = 1'b1;
                    end else if (timer >= 16'(`NCT_PRECHARGE_LIMIT_SEC)) begin
                        next_state  = NCT_FAULT;
                        events[`NCT_EVT_TIMEOUT] = 1'b1;
                        events[`NCT_EVT_FAULT]   = 1'b1;
                    end
                end
                NCT_FAST: begin
                    if (cell_open) begin
                        next_state  = NCT_PRESENCE;
                        timer_clear = 1'b1;
                    end else if (therm_stop) begin
                        next_state  = NCT_DONE;
                        events[`NCT_EVT_THSTOP] = 1'b1;
                        events[`NCT_EVT_DONE]   = 1'b1;
                    end else if (slope_hit) begin
                        next_state  = NCT_TOPOFF;
                        timer_clear = 1'b1;
                        events[`NCT_EVT_SLOPE] = 1'b1;
                    end else if (timer >= fast_limit) begin
                        next_state  = NCT_TOPOFF;
                        timer_clear = 1'b1;
                        events[`NCT_EVT_TIMEOUT] = 1'b1;
                    end
                end
                NCT_TOPOFF: begin
                    if (cell_open) begin
                        next_state  = NCT_PRESENCE;
                        timer_clear = 1'b1;
                    end else if (therm_stop) begin
                        next_state  = NCT_DONE;
                        events[`NCT_EVT_THSTOP] = 1'b1;
                        events[`NCT_EVT_DONE]   = 1'b1;
                    end else if (timer >= topoff_limit) begin
                        next_state  = NCT_DONE;
                        events[`NCT_EVT_DONE] = 1'b1;
                    end
                end
                NCT_DONE, NCT_FAULT: begin
                    if (cell_open) begin
                        next_state  = NCT_PRESENCE;
                        timer_clear = 1'b1;
                    end
                end
                NCT_DISCHARGE: begin
                    if (charge_current_detect) begin
                        next_state  = NCT_PRESENCE;
                        timer_clear = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state <= NCT_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Charge timer in seconds
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            timer <= 16'h0000;
        end else if (timer_clear) begin
            timer <= 16'h0000;
        end else if (charging && sec_tick && timer != 16'hFFFF) begin
            timer <= timer + 16'h0001;
        end
    end

    // Slope sampling once a minute after blanking
    always_ff @(posedge sys_clk) begin
        if (!reset_n || state != NCT_FAST || timer_clear) begin
            sec_in_min      <= 6'h00;
            slope_ref       <= 10'h000;
            slope_ref_valid <= 1'b0;
        end else if (sec_tick) begin
            if (sec_in_min == 6'(`NCT_SEC_PER_MIN - 1)) begin
                sec_in_min <= 6'h00;
                if (timer >= 16'(`NCT_BLANK_SEC)) begin
                    slope_ref       <= thermistor_sense_input;
                    slope_ref_valid <= 1'b1;
                end
            end else begin
                sec_in_min <= sec_in_min + 6'h01;
            end
        end
    end

    assign charging = (state == NCT_PRECHARGE) || (state == NCT_FAST) || (state == NCT_TOPOFF);

    // Regulation target and drive
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            fast_sense_target      <= 1'b0;
            sense_target_mv        <= 8'h00;
            charge_drive_output_en <= 1'b0;
        end else begin
            fast_sense_target      <= (state == NCT_FAST);
            charge_drive_output_en <= charging || (state == NCT_DISCHARGE);
            if (!charging) begin
                sense_target_mv <= 8'h00;
            end else if (regulation_style == NCT_STYLE_COMPARATOR) begin
                sense_target_mv <= (state == NCT_FAST) ? `NCT_CMP_FAST_MV : `NCT_CMP_TOPOFF_MV;
            end else begin
                sense_target_mv <= (state == NCT_FAST) ? `NCT_LIN_FAST_MV : `NCT_LIN_TOPOFF_MV;
            end
        end
    end

    // Indicators; released in presence, reset and discharge
    nct_indicator u_charge_ind (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .active  (charging),
        .blink   (1'b1),
        .phase   (eighth[2]),
        .pin_out (charge_indicator_out),
        .pin_oe  (charge_indicator_oe)
    );

    nct_indicator u_result_ind (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .active  ((state == NCT_DONE) || (state == NCT_FAULT)),
        .blink   (state == NCT_FAULT),
        .phase   (eighth[0]),
        .pin_out (result_indicator_out),
        .pin_oe  (result_indicator_oe)
    );

    // Control register and restart pulse
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctrl_enable <= `NCT_CTRL_RESET;
            restart_req <= 1'b0;
        end else begin
            restart_req <= 1'b0;
            if (reg_wr && reg_addr == `NCT_REG_CTRL) begin
                ctrl_enable <= reg_wdata[`NCT_CTRL_ENABLE_BIT];
                restart_req <= reg_wdata[`NCT_CTRL_RESTART_BIT];
            end
        end
    end

    // Sticky events, write one to clear, set wins
    always_comb begin
        next_status = status;
        if (reg_wr && reg_addr == `NCT_REG_STATUS) begin
            next_status = status & ~reg_wdata[`NCT_EVT_WIDTH-1:0];
        end
        next_status = next_status | events;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            status <= '0;
            mask   <= '0;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            irq    <= |(next_status & ((reg_wr && reg_addr == `NCT_REG_MASK)
                      ? reg_wdata[`NCT_EVT_WIDTH-1:0] : mask));
            if (reg_wr && reg_addr == `NCT_REG_MASK) begin
                mask <= reg_wdata[`NCT_EVT_WIDTH-1:0];
            end
        end
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `NCT_REG_CTRL:   reg_rdata <= {31'h00000000, ctrl_enable};
                `NCT_REG_STATUS: reg_rdata <= {27'h0000000, status};
                `NCT_REG_MASK:   reg_rdata <= {27'h0000000, mask};
                `NCT_REG_STATE:  reg_rdata <= {28'h0000000, regulation_style, state};
                `NCT_REG_TIMER:  reg_rdata <= {16'h0000, timer};
                `NCT_REG_THERM:  reg_rdata <= {22'h000000, thermistor_sense_input};
                default:         reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    // Checks
    property p_uvlo_reset;
        @(posedge sys_clk) disable iff (!reset_n)
        uvlo_active |=> (state == NCT_RESET) && (timer == 16'h0000);
    endproperty
    a_uvlo_reset: assert property (p_uvlo_reset) else $error("uvlo did not reset");

    property p_pre_timeout;
        @(posedge sys_clk) disable iff (!reset_n)
        (state == NCT_PRECHARGE) && no_override && !therm_stop && !above_precharge_exit_voltage
        && (timer >= 16'(`NCT_PRECHARGE_LIMIT_SEC)) |=> (state == NCT_FAULT);
    endproperty
    a_pre_timeout: assert property (p_pre_timeout) else $error("precharge limit missed");

    property p_fast_timeout;
        @(posedge sys_clk) disable iff (!reset_n)
        (state == NCT_FAST) && no_override && !therm_stop && (timer >= fast_limit)
        |=> (state == NCT_TOPOFF) && (timer == 16'h0000);
    endproperty
    a_fast_timeout: assert property (p_fast_timeout) else $error("fast timeout wrong");

    property p_half_limit;
        @(posedge sys_clk) disable iff (!reset_n)
        topoff_limit == 16'(rt_clamped * 16'(`NCT_FAST_SEC_PER_KOHM / 2));
    endproperty
    a_half_limit: assert property (p_half_limit) else $error("topoff limit not half");

    property p_topoff_end;
        @(posedge sys_clk) disable iff (!reset_n)
        (state == NCT_TOPOFF) && no_override && (timer >= topoff_limit) |=> (state == NCT_DONE);
    endproperty
    a_topoff_end: assert property (p_topoff_end) else $error("topoff did not end");

    property p_pre_stop;
        @(posedge sys_clk) disable iff (!reset_n)
        (state == NCT_PRECHARGE) && no_override && therm_stop |=> (state == NCT_FAULT);
    endproperty
    a_pre_stop: assert property (p_pre_stop) else $error("precharge stop not fault");

    property p_charge_stop;
        @(posedge sys_clk) disable iff (!reset_n)
        ((state == NCT_FAST) || (state == NCT_TOPOFF)) && no_override && therm_stop
        |=> (state == NCT_DONE) ##1 result_indicator_oe;
    endproperty
    a_charge_stop: assert property (p_charge_stop) else $error("charge stop not done");

    property p_start_range;
        @(posedge sys_clk) disable iff (!reset_n)
        (state == NCT_PRESENCE) ##1 (state == NCT_PRECHARGE) |-> $past(therm_in_range);
    endproperty
    a_start_range: assert property (p_start_range) else $error("start out of range");

    property p_released;
        @(posedge sys_clk) disable iff (!reset_n)
        (state == NCT_PRESENCE || state == NCT_DISCHARGE) [*2]
        |-> !charge_indicator_oe && !result_indicator_oe;
    endproperty
    a_released: assert property (p_released) else $error("indicator not released");

    property p_fast_target;
        @(posedge sys_clk) disable iff (!reset_n)
        (state == NCT_FAST) |=> fast_sense_target;
    endproperty
    a_fast_target: assert property (p_fast_target) else $error("fast target not set");

    c_done:  cover property (@(posedge sys_clk) state == NCT_TOPOFF ##1 state == NCT_DONE);
    c_fault: cover property (@(posedge sys_clk) state == NCT_PRECHARGE ##1 state == NCT_FAULT);
    c_slope: cover property (@(posedge sys_clk) slope_hit && state == NCT_FAST);
    c_irq:   cover property (@(posedge sys_clk) irq);

endmodule // nct_charge_ctrl

`default_nettype wire

/* File: dv/nct_far_side.sv */
// Far-side model: cell voltage and indicator wires
`timescale 1ns/1ps
`default_nettype none

module nct_far_side (
    input  wire logic sys_clk,
    input  wire logic drive_en,
    input  wire logic cell_ok,
    input  wire logic chg_out,
    input  wire logic chg_oe,
    input  wire logic res_out,
    input  wire logic res_oe,
    output wire logic above_exit,
    output wire logic chg_wire,
    output wire logic res_wire
);
    logic [3:0] rise_cnt;

    initial rise_cnt = 4'h0;
    // Cell voltage climbs only while drive is enabled on a good cell
    always @(posedge sys_clk) begin
        rise_cnt <= (drive_en && cell_ok) ? rise_cnt + {3'h0, rise_cnt != 4'hF} : 4'h0;
    end
    assign above_exit = rise_cnt == 4'hF;
    // Pull-ups on released lines
    assign chg_wire = chg_oe ? chg_out : 1'b1;
    assign res_wire = res_oe ? res_out : 1'b1;
endmodule // nct_far_side

`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench of the charge controller
`timescale 1ns/1ps
`default_nettype none
`include "nct_params.svh"

module tb;
    import nct_pkg::*;
    localparam int EC = 4;
    localparam int SEC = 8 * EC;
    logic        sys_clk, reset_n, uvlo, strap, ins, opn, dis, cok, wr, rd;
    logic        irq, fst, drv, c_out, c_oe, r_out, r_oe, above, c_w, r_w;
    logic [7:0]  rt, addr, tgt;
    logic [9:0]  therm;
    logic [31:0] wdata, rdata, v;
    nct_style_t  style;
    int          num_errors, total_checks, seed, n;

    nct_charge_ctrl #(.EIGHTH_CYCLES(EC)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .uvlo_active(uvlo), .mode_strap_bias(strap), .rt_kohm(rt),
        .thermistor_sense_input(therm), .cell_inserted(ins), .cell_open(opn),
        .above_precharge_exit_voltage(above), .discharge_detect(dis),
        .charge_current_detect(1'b0), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .irq(irq), .regulation_style(style),
        .fast_sense_target(fst), .sense_target_mv(tgt), .charge_drive_output_en(drv),
        .charge_indicator_out(c_out), .charge_indicator_oe(c_oe),
        .result_indicator_out(r_out), .result_indicator_oe(r_oe));
    nct_far_side i_far (.sys_clk(sys_clk), .drive_en(drv), .cell_ok(cok), .chg_out(c_out),
        .chg_oe(c_oe), .res_out(r_out), .res_oe(r_oe), .above_exit(above),
        .chg_wire(c_w), .res_wire(r_w));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] exp_mv(input logic cmp, input logic fast);
        if (cmp) return fast ? `NCT_CMP_FAST_MV : `NCT_CMP_TOPOFF_MV;
        return fast ? `NCT_LIN_FAST_MV : `NCT_LIN_TOPOFF_MV;
    endfunction
    // Inside the start window, open at both ends
    function automatic logic [9:0] rnd_therm();
        return 10'(339 + {$random(seed)} % 409);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wait_st(input logic [2:0] s, input int lim);
        n = 0;
        do begin
            rreg(`NCT_REG_STATE);
            n++;
        end while (v[2:0] !== s && n < lim);
        check(v[2:0], s);
    endtask
    // Counts cycles with each indicator wire pulled low
    task automatic leds(input int cyc, input int ec, input int er);
        int lc, lr;
        lc = 0;
        lr = 0;
        repeat (cyc) begin
            @(posedge sys_clk);
            #1 lc += !c_w;
            lr += !r_w;
        end
        check(lc, ec);
        check(lr, er);
        $display("part done, checks %0d", total_checks);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #2500000;
        num_errors++;
        final_report();
    end

    initial begin
        seed = 32'h8C32;
        {reset_n, uvlo, strap, ins, opn, dis, cok, wr, rd} = 9'h000;
        {rt, addr, wdata} = {8'h14, 8'h00, 32'h0};
        therm = `NCT_COLD_START_LIMIT;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        rreg(8'h18);
        check(v, 32'h0);
        wait_st(NCT_PRESENCE, 2);
        check(style, NCT_STYLE_LINEAR);
        ins <= 1'b1;
        repeat (8) rreg(`NCT_REG_STATE);
        check(v[2:0], NCT_PRESENCE);
        check(c_w, 1'b1);
        therm <= `NCT_HOT_START_LIMIT;
        repeat (8) rreg(`NCT_REG_STATE);
        check(v[2:0], NCT_PRESENCE);
        check(c_w, 1'b1);
        therm <= rnd_therm();
        wait_st(NCT_PRECHARGE, 8);
        check(tgt, exp_mv(1'b0, 1'b0));
        therm <= `NCT_THERMAL_STOP_LIMIT;
        wait_st(NCT_FAULT, 4);
        leds(32, 0, 16);
        therm <= rnd_therm();
        opn <= 1'b1;
        wait_st(NCT_PRESENCE, 4);
        opn <= 1'b0;
        cok <= 1'b1;
        wreg(`NCT_REG_MASK, 32'h1F);
        wreg(`NCT_REG_STATUS, 32'h1F);
        wait_st(NCT_FAST, 30);
        therm <= therm - 10'h014;
        check(fst, 1'b1);
        check(tgt, exp_mv(1'b0, 1'b1));
        leds(64, 32, 0);
        repeat (300 * SEC) @(posedge sys_clk);
        wait_st(NCT_FAST, 1);
        therm <= therm - 10'h006;
        wait_st(NCT_TOPOFF, 65 * SEC);
        rreg(`NCT_REG_STATUS);
        check(v[`NCT_EVT_SLOPE], 1'b1);
        check(irq, 1'b1);
        check(tgt, exp_mv(1'b0, 1'b0));
        therm <= `NCT_THERMAL_STOP_LIMIT;
        wait_st(NCT_DONE, 4);
        leds(32, 0, 32);
        therm <= rnd_therm();
        dis <= 1'b1;
        wait_st(NCT_DISCHARGE, 4);
        leds(32, 0, 0);
        uvlo <= 1'b1;
        wait_st(NCT_RESET, 4);
        rreg(`NCT_REG_TIMER);
        check(v, 32'h0);
        {uvlo, dis, reset_n, strap} <= 4'h1;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        wait_st(NCT_FAST, 40);
        check(style, NCT_STYLE_COMPARATOR);
        check(tgt, exp_mv(1'b1, 1'b1));
        wait_st(NCT_TOPOFF, 901 * SEC);
        check(2 * n >= 1799 * SEC, 1'b1);
        rreg(`NCT_REG_TIMER);
        check(v < 3, 1'b1);
        rreg(`NCT_REG_STATUS);
        check(v[`NCT_EVT_TIMEOUT], 1'b1);
        check(tgt, exp_mv(1'b1, 1'b0));
        // Masked timeout event raises irq, write one clears it
        wreg(`NCT_REG_MASK, 32'h08);
        rreg(`NCT_REG_STATUS);
        check(v, 32'h08);
        check(irq, 1'b1);
        wreg(`NCT_REG_STATUS, 32'h08);
        rreg(`NCT_REG_STATUS);
        check(v, 32'h0);
        check(irq, 1'b0);
        // Restart with start disabled parks in presence
        wreg(`NCT_REG_CTRL, 32'h2);
        wait_st(NCT_PRESENCE, 2);
        leds(32, 0, 0);
        wait_st(NCT_PRESENCE, 1);
        final_report();
    end
endmodule // tb

`default_nettype wire
